// ===== pkg/ioc_defs.svh
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH

// Register byte offsets on the APB slave.
`define IOC_OFF_CFG     8'h00
`define IOC_OFF_STATUS  8'h04

// Configuration register field positions.
`define IOC_CFG_W         13
`define IOC_CFG_FCL_EN    0
`define IOC_CFG_STG_LATCH 1
`define IOC_CFG_INV_CAP   2
`define IOC_CFG_INV_STG   3
`define IOC_CFG_DLY_LO    4
`define IOC_CFG_DLY_HI    5
`define IOC_CFG_OREG_EN   6
`define IOC_CFG_OUT_INV   7
`define IOC_CFG_TS_INV    8
`define IOC_CFG_INIT_SET  9
`define IOC_CFG_OPEN_DRN  10
`define IOC_CFG_CE_USED   11
`define IOC_CFG_TS_USED   12

// Configuration reset value: everything off, delay automatic, clear on init.
`define IOC_CFG_RST 13'h0000

// Status register field positions.
`define IOC_ST_PAD    0
`define IOC_ST_CAP    1
`define IOC_ST_STAGE  2
`define IOC_ST_OREG   3
`define IOC_ST_HIZ    4

// Timing counts in clock cycles.
`define IOC_SYNC_STAGES 2
`define IOC_MED_TAPS    1
`define IOC_FULL_TAPS   2

`endif

// ===== pkg/ioc_pkg.sv
`default_nettype none

package ioc_pkg;

  // Input delay selection; automatic picks medium while the capture latch is used.
  typedef enum logic [1:0] {
    IOC_DLY_AUTO,
    IOC_DLY_NONE,
    IOC_DLY_MED,
    IOC_DLY_FULL
  } ioc_dly_t;

endpackage : ioc_pkg

`default_nettype wire

// ===== design/ioc_delay_line.sv
`default_nettype none

module ioc_delay_line import ioc_pkg::*; #(
  parameter int DEPTH = 2
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       d_i,
  input  wire logic [$clog2(DEPTH+1)-1:0] tap_i,
  output logic                            q_o
);

  logic [DEPTH:0] tap_w;

  // Elaboration guard: a chain without flops cannot delay anything.
  if (DEPTH < 1) begin : g_bad_depth
    $error("ioc_delay_line needs at least one tap");
  end

  // Tap zero is the undelayed input.
  assign tap_w[0] = d_i;

  // One flip-flop per tap; taps are chained so each adds one cycle.
  for (genvar k = 1; k <= DEPTH; k++) begin : g_tap
    logic tap_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        tap_ff <= 1'b0;
      end else begin
        tap_ff <= tap_w[k-1];
      end
    end
    assign tap_w[k] = tap_ff;
  end

  // Out-of-range tap numbers fall back to the longest delay.
  assign q_o = (int'(tap_i) > DEPTH) ? tap_w[DEPTH] : tap_w[tap_i];

endmodule // ioc_delay_line

`default_nettype wire

// ===== design/ioc_cell.sv
// Added by the designer: the APB register port and the register addresses.
`include "ioc_defs.svh"
`default_nettype none

module ioc_cell import ioc_pkg::*; #(
  parameter logic [`IOC_CFG_W-1:0] P_CFG_RST   = `IOC_CFG_RST,
  parameter int                    P_MED_TAPS  = `IOC_MED_TAPS,
  parameter int                    P_FULL_TAPS = `IOC_FULL_TAPS
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Clock pins of the cell, asynchronous to mclk_i.
  input  wire logic        early_clk_i,
  input  wire logic        lowskew_clk_i,
  // Internal logic side, on mclk_i.
  input  wire logic        out_data_i,
  input  wire logic        out_ce_i,
  input  wire logic        out_ts_i,
  input  wire logic        global_set_reset_i,
  input  wire logic        global_tristate_i,
  input  wire logic        extest_i,
  output logic             in_data_o,
  // Pad.
  input  wire logic        pad_i,
  output logic             pad_o,
  output logic             pad_oe_n_o
);

  localparam int TAPW = $clog2(P_FULL_TAPS + 1);

  // Elaboration guard: the delay chain must serve both tap settings.
  if (P_MED_TAPS < 1 || P_FULL_TAPS < P_MED_TAPS) begin : g_bad_taps
    $error("ioc_cell needs 1 <= P_MED_TAPS <= P_FULL_TAPS");
  end

  logic [`IOC_CFG_W-1:0]          cfg_ff;
  logic [`IOC_CFG_W-1:0]          nxt_cfg;
  logic [`IOC_SYNC_STAGES-1:0]    sync_pad_ff;
  logic [`IOC_SYNC_STAGES-1:0]    sync_early_ff;
  logic [`IOC_SYNC_STAGES-1:0]    sync_lsk_ff;
  logic                           early_prev_ff;
  logic                           stg_prev_ff;
  logic                           cap_ff;
  logic                           stage_ff;
  logic                           oreg_ff;
  logic                           pad_ff;
  logic                           oe_n_ff;
  logic [31:0]                    rdata_ff;
  logic                           ready_ff;
  logic                           err_ff;
  logic                           pad_s;
  logic                           early_s;
  logic                           lsk_s;
  logic                           pad_dly;
  logic [TAPW-1:0]                dly_tap;
  ioc_dly_t                       dly_cfg;
  ioc_dly_t                       dly_eff;
  logic                           fcl_en;
  logic                           stg_latch;
  logic                           cap_clk;
  logic                           stg_clk;
  logic                           stg_rise;
  logic                           oclk_rise;
  logic                           stage_in;
  logic                           ce_eff;
  logic                           ts_eff;
  logic                           out_val;
  logic                           drv_val;
  logic                           od_en;
  logic                           t_raw;
  logic                           t_pol;
  logic                           hiz;
  logic                           nxt_pad;
  logic                           addr_cfg;
  logic                           addr_st;
  logic                           setup;
  logic                           wr_cfg;
  logic [31:0]                    nxt_rdata;
  logic [31:0]                    status_w;

  // Pins from other domains pass two flops; only the last stage is read.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_pad_ff   <= '0;
      sync_early_ff <= '0;
      sync_lsk_ff   <= '0;
    end else begin
      sync_pad_ff   <= {sync_pad_ff[0], pad_i};
      sync_early_ff <= {sync_early_ff[0], early_clk_i};
      sync_lsk_ff   <= {sync_lsk_ff[0], lowskew_clk_i};
    end
  end
  assign pad_s   = sync_pad_ff[`IOC_SYNC_STAGES-1];
  assign early_s = sync_early_ff[`IOC_SYNC_STAGES-1];
  assign lsk_s   = sync_lsk_ff[`IOC_SYNC_STAGES-1];

  // Configuration field decode.
  assign fcl_en    = cfg_ff[`IOC_CFG_FCL_EN];
  assign stg_latch = cfg_ff[`IOC_CFG_STG_LATCH];
  assign dly_cfg   = ioc_dly_t'(cfg_ff[`IOC_CFG_DLY_HI:`IOC_CFG_DLY_LO]);
  assign od_en     = cfg_ff[`IOC_CFG_OPEN_DRN];

  assign dly_eff = (dly_cfg == IOC_DLY_AUTO) ? (fcl_en ? IOC_DLY_MED : IOC_DLY_NONE) : dly_cfg;
  assign dly_tap = (dly_eff == IOC_DLY_MED)  ? TAPW'(P_MED_TAPS) :
                   (dly_eff == IOC_DLY_FULL) ? TAPW'(P_FULL_TAPS) : '0;

  ioc_delay_line #(
    .DEPTH (P_FULL_TAPS)
  ) u_delay (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (pad_s),
    .tap_i   (dly_tap),
    .q_o     (pad_dly)
  );

  assign cap_clk  = early_s ^ cfg_ff[`IOC_CFG_INV_CAP];
  assign stg_clk  = lsk_s ^ cfg_ff[`IOC_CFG_INV_STG];
  assign stg_rise = stg_clk & ~stg_prev_ff;
  assign oclk_rise = early_s & ~early_prev_ff;
  // Without the capture latch the stage sees the delayed pad directly.
  assign stage_in = fcl_en ? cap_ff : pad_dly;

  // Edge detection history for the sampled cell clocks.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      early_prev_ff <= 1'b0;
      stg_prev_ff   <= 1'b0;
    end else begin
      early_prev_ff <= early_s;
      stg_prev_ff   <= stg_clk;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_ff <= 1'b0;
    end else if (!cap_clk) begin
      cap_ff <= pad_dly;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_ff <= 1'b0;
    end else if (stg_latch ? stg_clk : stg_rise) begin
      stage_ff <= stage_in;
    end
  end
  assign in_data_o = stage_ff;

  assign ce_eff = cfg_ff[`IOC_CFG_CE_USED] ? out_ce_i : 1'b1;
  assign ts_eff = cfg_ff[`IOC_CFG_TS_USED] ? out_ts_i : 1'b0;
  assign out_val = out_data_i ^ cfg_ff[`IOC_CFG_OUT_INV];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oreg_ff <= P_CFG_RST[`IOC_CFG_INIT_SET];
    end else if (global_set_reset_i) begin
      oreg_ff <= cfg_ff[`IOC_CFG_INIT_SET];
    end else if (oclk_rise && ce_eff) begin
      oreg_ff <= out_val;
    end
  end

  assign drv_val = cfg_ff[`IOC_CFG_OREG_EN] ? oreg_ff : out_val;
  // open drain uses data as tristate
  assign t_raw   = od_en ? drv_val : ts_eff;
  assign nxt_pad = od_en ? 1'b0 : drv_val;
  assign t_pol   = t_raw ^ cfg_ff[`IOC_CFG_TS_INV];
  assign hiz     = t_pol | (global_tristate_i & ~extest_i);

  // Pad drivers are registered so the pin never sees decode glitches.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      pad_ff  <= nxt_pad;
      oe_n_ff <= hiz;
    end
  end
  assign pad_o      = pad_ff;
  assign pad_oe_n_o = oe_n_ff;

  // APB decode; the answer comes in the first access cycle.
  assign addr_cfg  = (paddr_i == `IOC_OFF_CFG);
  assign addr_st   = (paddr_i == `IOC_OFF_STATUS);
  assign setup     = psel_i & ~penable_i;
  assign wr_cfg    = psel_i & penable_i & ready_ff & pwrite_i & addr_cfg;
  assign status_w  = 32'({hiz, oreg_ff, stage_ff, cap_ff, pad_s});
  assign nxt_rdata = addr_cfg ? 32'(cfg_ff) : (addr_st ? status_w : 32'h0000_0000);
  // options change only by a configuration write
  assign nxt_cfg   = wr_cfg ? pwdata_i[`IOC_CFG_W-1:0] : cfg_ff;

  // Configuration register; reset value comes from the cell parameters.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_ff <= P_CFG_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Bus answer flops; status reads show the sampled state at setup.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ready_ff <= setup;
      err_ff   <= setup & ~addr_cfg & ~(addr_st & ~pwrite_i);
      rdata_ff <= setup ? nxt_rdata : 32'h0000_0000;
    end
  end
  assign pready_o  = ready_ff;
  assign pslverr_o = err_ff;
  assign prdata_o  = rdata_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_ts_floats: assert property (
    (cfg_ff[`IOC_CFG_TS_USED] && out_ts_i && !od_en && !cfg_ff[`IOC_CFG_TS_INV])
      |=> pad_oe_n_o)
    else $error("Tristate high did not float the pad.");

  a_gts_floats: assert property (
    (global_tristate_i && !extest_i) |=> pad_oe_n_o)
    else $error("Global tristate did not float the pad.");

  a_extest_keeps: assert property (
    (global_tristate_i && extest_i && !t_pol) |=> !pad_oe_n_o)
    else $error("Extest did not keep the pad driven.");

  a_oreg_load: assert property (
    (oclk_rise && ce_eff && !global_set_reset_i) |=> (oreg_ff == $past(out_val)))
    else $error("Output register missed a load.");

  a_oreg_hold: assert property (
    (!ce_eff && !global_set_reset_i) |=> $stable(oreg_ff))
    else $error("Output register changed with enable low.");

  a_gsr_init: assert property (
    global_set_reset_i |=> (oreg_ff == $past(cfg_ff[`IOC_CFG_INIT_SET])))
    else $error("Global set/reset did not load the init value.");

  a_od_drive: assert property (
    (od_en && !global_tristate_i) |=> (!pad_o && (pad_oe_n_o == $past(t_pol))))
    else $error("Open drain output drove a high level.");

  a_direct_out: assert property (
    (!cfg_ff[`IOC_CFG_OREG_EN] && !od_en) |=> (pad_o == $past(out_val)))
    else $error("Direct output path lost its value.");

  a_cap_hold: assert property (
    (cap_clk && !wr_cfg) |=> $stable(cap_ff))
    else $error("Capture latch moved while closed.");

  a_stage_flop: assert property (
    (!stg_latch && !stg_rise && !wr_cfg) |=> $stable(stage_ff))
    else $error("Input flop changed without a rising edge.");

  a_stage_latch: assert property (
    (stg_latch && stg_clk) |=> (stage_ff == $past(stage_in)))
    else $error("Input latch did not follow while open.");

  a_dly_auto: assert property (
    (fcl_en && dly_cfg == IOC_DLY_AUTO) |-> (dly_tap == TAPW'(P_MED_TAPS)))
    else $error("Capture latch use did not pick medium delay.");

  a_apb_answer: assert property (
    setup |=> (pready_o ##1 !pready_o))
    else $error("APB answer was not a single cycle.");

  c_fcl_flop: cover property (fcl_en && !stg_latch && stg_rise);
  c_fcl_latch: cover property (fcl_en && stg_latch && stg_clk);
  c_oreg_load: cover property (cfg_ff[`IOC_CFG_OREG_EN] && oclk_rise && ce_eff);
  c_open_drain: cover property (od_en && !pad_oe_n_o);

endmodule // ioc_cell

`default_nettype wire

// ===== testbench/ioc_pad_model.sv
`default_nettype none

module ioc_pad_model (
  input  wire logic cell_val_i,
  input  wire logic cell_oe_n_i,
  input  wire logic drv_en_i,
  input  wire logic drv_val_i,
  output logic      pad_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // released pad
  // A released line follows the board driver when drv_en_i is set and goes to the pull-up otherwise, so a floating cell never reads as a stale value.
  assign pad_o = !cell_oe_n_i ? cell_val_i : (drv_en_i ? drv_val_i : 1'b1);

endmodule // ioc_pad_model

`default_nettype wire

// ===== testbench/test_io_cell_capture_output_path.sv
`include "ioc_defs.svh"
`default_nettype none

module test_io_cell_capture_output_path import ioc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk_i, rst_n_i, psel, penable, pwrite, early, lowskew;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, d, ce, ts, global_set_reset, global_tristate, ext, in_data, pad_i, pad_o, pad_oe_n;
  logic        drv_en, drv_val;
  int          errors, check_count;

  // Rows: config, then d ts gts extest, then expected pad value and output enable.
  localparam logic [18:0] ROWS [12] = '{
    {13'h0000, 6'b100010}, {13'h0000, 6'b000000}, {13'h0080, 6'b100000},
    {13'h0000, 6'b010000}, {13'h1000, 6'b110001}, {13'h1100, 6'b110010},
    {13'h1100, 6'b000001}, {13'h0000, 6'b101001}, {13'h0000, 6'b101110},
    {13'h0400, 6'b100001}, {13'h0400, 6'b000000}, {13'h0480, 6'b100000}};

  ioc_cell dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .early_clk_i(early), .lowskew_clk_i(lowskew),
    .out_data_i(d), .out_ce_i(ce), .out_ts_i(ts), .global_set_reset_i(global_set_reset),
    .global_tristate_i(global_tristate), .extest_i(ext), .in_data_o(in_data), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_n_o(pad_oe_n));

  ioc_pad_model board (.cell_val_i(pad_o), .cell_oe_n_i(pad_oe_n), .drv_en_i(drv_en),
    .drv_val_i(drv_val), .pad_o(pad_i));

  // Free-running system clock at 200 MHz.
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at an edge.
  // There is no local limit: only the watchdog ends a slave that never answers.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge mclk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [12:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `IOC_OFF_CFG, {19'h0, v}, r, e);
  endtask

  // Clock pulses last several cycles because the cell samples its clock pins.
  task automatic ls_pulse();
    lowskew <= 1'b1;
    wt(6);
    lowskew <= 1'b0;
    wt(6);
  endtask

  task automatic ea_pulse();
    early <= 1'b1;
    wt(6);
    early <= 1'b0;
    wt(6);
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    errors++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    logic [18:0] w;
    errors = 0;
    check_count = 0;
    {rst_n_i, psel, penable, pwrite, early, lowskew, d, ce, ts, global_set_reset, global_tristate, ext} = '0;
    {drv_en, drv_val, paddr, pwdata} = '0;
    wt(8);
    chk(pad_oe_n, 1'b1);
    rst_n_i <= 1'b1;
    // Register bus: reset value, write-back of the stored bits, refused accesses.
    apb(1'b0, `IOC_OFF_CFG, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    chk(e, 1'b0);
    apb(1'b1, `IOC_OFF_CFG, 32'hFFFF_FFFF, r, e);
    apb(1'b0, `IOC_OFF_CFG, 32'h0, r, e);
    chk(r, 32'h0000_1FFF);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    chk(e, 1'b1);
    apb(1'b1, `IOC_OFF_STATUS, 32'h0, r, e);
    chk(e, 1'b1);
    $display("test apb done");
    // Direct output path across polarity, tristate and open-drain settings.
    for (int i = 0; i < 12; i++) begin
      w = ROWS[i];
      cfg(w[18:6]);
      {d, ts, global_tristate, ext} <= w[5:2];
      wt(4);
      chk({pad_oe_n, w[0] ? 1'b0 : pad_o}, {w[0], w[0] ? 1'b0 : w[1]});
    end
    $display("test rows done");
    // Output register: init value, edge load, enable and set/reset.
    {ts, global_tristate, ext} <= 3'b000;
    cfg(13'h0040);
    d <= 1'b1;
    global_set_reset <= 1'b1;
    wt(3);
    global_set_reset <= 1'b0;
    wt(3);
    chk(pad_o, 1'b0);
    ea_pulse();
    chk(pad_o, 1'b1);
    cfg(13'h0840);
    d <= 1'b0;
    ea_pulse();
    chk(pad_o, 1'b1);
    ce <= 1'b1;
    ea_pulse();
    chk(pad_o, 1'b0);
    cfg(13'h0240);
    global_set_reset <= 1'b1;
    wt(3);
    global_set_reset <= 1'b0;
    wt(3);
    chk(pad_o, 1'b1);
    $display("test oreg done");
    // Flop stage loads only on a rising stage clock.
    ts <= 1'b1;
    drv_en <= 1'b1;
    drv_val <= 1'b1;
    cfg(13'h1000);
    wt(8);
    ls_pulse();
    chk(in_data, 1'b1);
    drv_val <= 1'b0;
    wt(10);
    chk(in_data, 1'b1);
    ls_pulse();
    chk(in_data, 1'b0);
    // Latch stage follows the pad while its clock is high.
    cfg(13'h1002);
    lowskew <= 1'b1;
    drv_val <= 1'b1;
    wt(10);
    chk(in_data, 1'b1);
    lowskew <= 1'b0;
    wt(6);
    drv_val <= 1'b0;
    wt(10);
    chk(in_data, 1'b1);
    // Capture latch closes on the early clock, stage retimes on low-skew.
    cfg(13'h1001);
    drv_val <= 1'b1;
    wt(10);
    early <= 1'b1;
    wt(8);
    drv_val <= 1'b0;
    wt(10);
    ls_pulse();
    chk(in_data, 1'b1);
    early <= 1'b0;
    wt(10);
    ls_pulse();
    chk(in_data, 1'b0);
    // Inverted capture clock opens the latch while the early pin is high.
    cfg(13'h1005);
    drv_val <= 1'b1;
    wt(10);
    ls_pulse();
    chk(in_data, 1'b0);
    early <= 1'b1;
    wt(10);
    ls_pulse();
    chk(in_data, 1'b1);
    // Status: floating pad, register cleared by the early edges, stage, capture, pad.
    apb(1'b0, `IOC_OFF_STATUS, 32'h0, r, e);
    chk(r, 32'h0000_0017);
    chk(e, 1'b0);
    // Full delay: two extra cycles between the synced pad and the open latch stage.
    cfg(13'h1032);
    lowskew <= 1'b1;
    drv_val <= 1'b0;
    wt(10);
    chk(in_data, 1'b0);
    drv_val <= 1'b1;
    wt(4);
    @(negedge mclk_i);
    chk(in_data, 1'b0);
    @(negedge mclk_i);
    chk(in_data, 1'b1);
    // No delay: the open latch stage takes the synced pad at once.
    cfg(13'h1012);
    wt(10);
    drv_val <= 1'b0;
    wt(2);
    @(negedge mclk_i);
    chk(in_data, 1'b1);
    @(negedge mclk_i);
    chk(in_data, 1'b0);
    // Inverted stage clock: the flop loads when the low-skew pin falls.
    cfg(13'h1008);
    drv_val <= 1'b1;
    wt(10);
    chk(in_data, 1'b0);
    lowskew <= 1'b0;
    wt(8);
    chk(in_data, 1'b1);
    $display("test input done");
    // Reset in mid-run returns the outputs and the configuration to idle.
    rst_n_i <= 1'b0;
    wt(2);
    chk({pad_oe_n, pad_o, in_data}, 3'b100);
    rst_n_i <= 1'b1;
    apb(1'b0, `IOC_OFF_CFG, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    $display("test reset done");
    finish_test();
  end

endmodule // test_io_cell_capture_output_path

`default_nettype wire
